// >>> rtl/emb_consts.svh
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH

// Register indices; the APB byte address is four times the index.
`define EMB_IDX_PB_DATA     9'h0e2
`define EMB_IDX_PB_DIR      9'h0f2
`define EMB_IDX_PB_FSEL     9'h0f4
`define EMB_IDX_MSG_CTRL    9'h104
`define EMB_IDX_STATUS      9'h105

// Message control register fields.
`define EMB_CTRL_EMA_BIT    0
`define EMB_CTRL_BANK_LO    4
`define EMB_CTRL_BANK_HI    7
`define EMB_CTRL_MASK_LO    8
`define EMB_CTRL_MASK_HI    11

// Status register fields.
`define EMB_STAT_EMA_BIT    0
`define EMB_STAT_REG_LO     1
`define EMB_STAT_REG_HI     2
`define EMB_STAT_BANK_LO    4
`define EMB_STAT_BANK_HI    7

// Reset values.
`define EMB_RST_PB_DATA     16'h0000
`define EMB_RST_PB_DIR      16'h0000
`define EMB_RST_PB_FSEL     16'h0000
`define EMB_RST_BANK        4'h0
`define EMB_RST_MASK        4'hf

// Port B positions of the four bank lines.
`define EMB_BANK_LINE_0     8
`define EMB_BANK_LINE_1     9
`define EMB_BANK_LINE_2     13
`define EMB_BANK_LINE_3     14

// Address map: on-chip resources end here, and bit 15 clear marks the banked region.
`define EMB_ONCHIP_TOP      16'h01ff
`define EMB_MAIN_BIT        15

`endif

// >>> rtl/emb_pkg.sv
package emb_pkg;

	// Region that a memory access falls into.
	typedef enum logic [1:0] {
		EMB_REG_NONE   = 2'b00,
		EMB_REG_ONCHIP = 2'b01,
		EMB_REG_MAIN   = 2'b10,
		EMB_REG_BANK   = 2'b11
	} emb_region_e;

	// Memory request from the core.
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} emb_mem_req_s;

	// Decoded memory access, one cycle after the request.
	typedef struct packed {
		logic        valid;
		logic        onchip;
		logic        ext;
		logic        banked;
		logic [15:0] addr;
	} emb_mem_rsp_s;

	// State of one Port B pin driver.
	typedef struct packed {
		logic out;
		logic oe_n;
	} emb_pin_s;

	// State of the bank select block.
	typedef struct packed {
		logic [15:0]  pb_data;
		logic [15:0]  pb_dir;
		logic [15:0]  pb_fsel;
		logic         extended_addressing_enable;
		logic [3:0]   bank;
		logic [3:0]   mask;
		logic [3:0]   bank_q;
		emb_region_e  last_region;
		emb_mem_rsp_s rsp;
		logic [31:0]  prdata;
	} emb_top_s;

endpackage

// >>> rtl/emb_pin_mux.sv
`timescale 1ns/1ps

module emb_pin_mux (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic extended_addressing_enable,
	input  wire logic bank_use,
	input  wire logic bank_bit,
	input  wire logic fsel,
	input  wire logic dir,
	input  wire logic gp_data,
	input  wire logic sync_data,
	output logic      pin_out,
	output logic      pin_oe_n
);
	import emb_pkg::*;

	emb_pin_s st;
	emb_pin_s next_st;

	// Pick the owner of the pin; bank duty overrides the port function.
	always_comb begin
		next_st = st;
		if (extended_addressing_enable) begin
			if (bank_use) begin
				next_st.out  = bank_bit;
				next_st.oe_n = 1'b0;
			end else begin
				next_st.out  = 1'b0;
				next_st.oe_n = 1'b1;
			end
		end else if (fsel) begin
			next_st.out  = sync_data;
			next_st.oe_n = 1'b0;
		end else begin
			next_st.out  = gp_data;
			next_st.oe_n = ~dir;
		end
	end

	// Pins come up as inputs so nothing fights the board at power-up.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '{out: 1'b0, oe_n: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign pin_out  = st.out;
	assign pin_oe_n = st.oe_n;

endmodule

// >>> rtl/emb_top.sv
`timescale 1ns/1ps
`include "emb_consts.svh"

module emb_top (
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	input  wire logic [11:0]          paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire emb_pkg::emb_mem_req_s mem_req,
	output emb_pkg::emb_mem_rsp_s     mem_rsp,
	input  wire logic [15:0]          sync_out_data,
	input  wire logic [15:0]          port_b_in,
	output logic [15:0]               port_b_out,
	output logic [15:0]               port_b_oe_n,
	output logic [3:0]                bank_lines
);
	import emb_pkg::*;

	emb_top_s    st;
	emb_top_s    next_st;
	logic [8:0]  idx;
	logic        setup;
	logic        access;
	logic        mapped;
	logic        read_only;
	logic [15:0] rd_word;
	logic [15:0] wr_mask;
	logic [15:0] ctrl_word;
	logic [15:0] stat_word;
	logic [15:0] bank_use_v;
	logic [15:0] bank_val_v;
	emb_region_e region;

	// APB decode; the register index sits above the two byte-offset bits.
	assign idx    = paddr[10:2];
	assign setup  = psel & ~penable;
	assign access = psel & penable;

	always_comb begin
		mapped = (paddr[1:0] == 2'b00) && !paddr[11] &&
			((idx == `EMB_IDX_PB_DATA) || (idx == `EMB_IDX_PB_DIR) ||
			 (idx == `EMB_IDX_PB_FSEL) || (idx == `EMB_IDX_MSG_CTRL) ||
			 (idx == `EMB_IDX_STATUS));
		read_only = (idx == `EMB_IDX_STATUS);
	end

	// Register views built from the state fields.
	always_comb begin
		ctrl_word = 16'h0000;
		ctrl_word[`EMB_CTRL_EMA_BIT]                  = st.extended_addressing_enable;
		ctrl_word[`EMB_CTRL_BANK_HI:`EMB_CTRL_BANK_LO] = st.bank;
		ctrl_word[`EMB_CTRL_MASK_HI:`EMB_CTRL_MASK_LO] = st.mask;
		stat_word = 16'h0000;
		stat_word[`EMB_STAT_EMA_BIT]                  = st.extended_addressing_enable;
		stat_word[`EMB_STAT_REG_HI:`EMB_STAT_REG_LO]   = st.last_region;
		stat_word[`EMB_STAT_BANK_HI:`EMB_STAT_BANK_LO] = st.bank_q;
	end

	// Read mux; the data register returns the pin levels, as a port read should.
	always_comb begin
		case (idx)
			`EMB_IDX_PB_DATA:  rd_word = port_b_in;
			`EMB_IDX_PB_DIR:   rd_word = st.pb_dir;
			`EMB_IDX_PB_FSEL:  rd_word = st.pb_fsel;
			`EMB_IDX_MSG_CTRL: rd_word = ctrl_word;
			`EMB_IDX_STATUS:   rd_word = stat_word;
			default:           rd_word = 16'h0000;
		endcase
		if (!mapped) begin
			rd_word = 16'h0000;
		end
	end

	// Byte lanes 0 and 1 carry the 16-bit registers; upper lanes are ignored.
	assign wr_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// Classify the address; only the low half outside on-chip space is banked.
	always_comb begin
		if (!mem_req.valid) begin
			region = EMB_REG_NONE;
		end else if (mem_req.addr <= `EMB_ONCHIP_TOP) begin
			region = EMB_REG_ONCHIP;
		end else if (mem_req.addr[`EMB_MAIN_BIT] || !st.extended_addressing_enable) begin
			region = EMB_REG_MAIN;
		end else begin
			region = EMB_REG_BANK;
		end
	end

	// Next state: register writes, read capture and memory decode.
	always_comb begin
		logic [15:0] ctrl_new;
		ctrl_new = (ctrl_word & ~wr_mask) | (pwdata[15:0] & wr_mask);
		next_st  = st;
		// Read data is captured in the setup cycle so prdata comes from a flop.
		if (setup) begin
			next_st.prdata = {16'h0000, rd_word};
		end
		if (access && pwrite && mapped && !read_only) begin
			case (idx)
				`EMB_IDX_PB_DATA: begin
					next_st.pb_data = (st.pb_data & ~wr_mask) | (pwdata[15:0] & wr_mask);
				end
				`EMB_IDX_PB_DIR: begin
					next_st.pb_dir = (st.pb_dir & ~wr_mask) | (pwdata[15:0] & wr_mask);
				end
				`EMB_IDX_PB_FSEL: begin
					next_st.pb_fsel = (st.pb_fsel & ~wr_mask) | (pwdata[15:0] & wr_mask);
				end
				`EMB_IDX_MSG_CTRL: begin
					next_st.extended_addressing_enable  = ctrl_new[`EMB_CTRL_EMA_BIT];
					next_st.bank = ctrl_new[`EMB_CTRL_BANK_HI:`EMB_CTRL_BANK_LO];
					next_st.mask = ctrl_new[`EMB_CTRL_MASK_HI:`EMB_CTRL_MASK_LO];
				end
				default: begin
					next_st.pb_data = st.pb_data;
				end
			endcase
		end
		// The bank on the pins moves only for a banked access; main and on-chip
		// accesses leave it alone so a shared routine never disturbs it.
		if (region == EMB_REG_BANK) begin
			next_st.bank_q = st.bank;
		end
		if (region != EMB_REG_NONE) begin
			next_st.last_region = region;
		end
		next_st.rsp.valid  = mem_req.valid;
		next_st.rsp.onchip = (region == EMB_REG_ONCHIP);
		next_st.rsp.ext    = (region == EMB_REG_MAIN) || (region == EMB_REG_BANK);
		next_st.rsp.banked = (region == EMB_REG_BANK);
		next_st.rsp.addr   = mem_req.addr;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st.pb_data     <= `EMB_RST_PB_DATA;
			st.pb_dir      <= `EMB_RST_PB_DIR;
			st.pb_fsel     <= `EMB_RST_PB_FSEL;
			st.extended_addressing_enable         <= 1'b0;
			st.bank        <= `EMB_RST_BANK;
			st.mask        <= `EMB_RST_MASK;
			st.bank_q      <= `EMB_RST_BANK;
			st.last_region <= EMB_REG_NONE;
			st.rsp         <= '0;
			st.prdata      <= 32'h0000_0000;
		end else begin
			st <= next_st;
		end
	end

	// Zero-wait slave; reserved or misaligned addresses answer with an error.
	assign pready  = access;
	assign pslverr = access & (!mapped | (pwrite & read_only));
	assign prdata  = st.prdata;
	assign mem_rsp = st.rsp;

	// Spread the four bank bits and their use mask onto the Port B positions.
	always_comb begin
		bank_use_v = 16'h0000;
		bank_val_v = 16'h0000;
		bank_use_v[`EMB_BANK_LINE_0] = st.mask[0];
		bank_use_v[`EMB_BANK_LINE_1] = st.mask[1];
		bank_use_v[`EMB_BANK_LINE_2] = st.mask[2];
		bank_use_v[`EMB_BANK_LINE_3] = st.mask[3];
		bank_val_v[`EMB_BANK_LINE_0] = st.bank_q[0];
		bank_val_v[`EMB_BANK_LINE_1] = st.bank_q[1];
		bank_val_v[`EMB_BANK_LINE_2] = st.bank_q[2];
		bank_val_v[`EMB_BANK_LINE_3] = st.bank_q[3];
	end

	// One driver per Port B pin; lines outside the bank set never see ema.
	for (genvar i = 0; i < 16; i++) begin : g_pin
		localparam logic IS_BANK = (i == `EMB_BANK_LINE_0) || (i == `EMB_BANK_LINE_1) ||
			(i == `EMB_BANK_LINE_2) || (i == `EMB_BANK_LINE_3);
		emb_pin_mux u_pin (
			.sys_clk   (sys_clk),
			.resetn    (resetn),
			.extended_addressing_enable       (st.extended_addressing_enable & IS_BANK),
			.bank_use  (bank_use_v[i]),
			.bank_bit  (bank_val_v[i]),
			.fsel      (st.pb_fsel[i]),
			.dir       (st.pb_dir[i]),
			.gp_data   (st.pb_data[i]),
			.sync_data (sync_out_data[i]),
			.pin_out   (port_b_out[i]),
			.pin_oe_n  (port_b_oe_n[i])
		);
	end

	assign bank_lines = st.bank_q;

endmodule

// >>> tb/emb_top_asserts.sv
`timescale 1ns/1ps
module emb_top_asserts (
	input wire logic                  sys_clk,
	input wire logic                  resetn,
	input wire logic [11:0]           paddr,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire emb_pkg::emb_mem_req_s mem_req,
	input wire emb_pkg::emb_mem_rsp_s mem_rsp,
	input wire logic [15:0]           port_b_out,
	input wire logic [15:0]           port_b_oe_n,
	input wire logic [3:0]            bank_lines
);
	import emb_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Decode relations; a wrong boundary shows up one cycle after the request.
	AST_ONCHIP: assert property (mem_req.valid && mem_req.addr <= 16'h01ff |=>
		mem_rsp.onchip && !mem_rsp.ext) else $error("onchip decode wrong");
	AST_MAIN: assert property (mem_req.valid && mem_req.addr[15] |=>
		mem_rsp.ext && !mem_rsp.banked) else $error("main decode wrong");
	AST_HOLD: assert property (mem_rsp.valid && !mem_rsp.banked |->
		$stable(bank_lines)) else $error("bank changed on unbanked access");
	AST_RANGE: assert property (mem_rsp.banked |->
		mem_rsp.addr > 16'h01ff && !mem_rsp.addr[15]) else $error("bank outside window");
	AST_RSP: assert property (mem_req.valid |=>
		mem_rsp.valid && mem_rsp.addr == $past(mem_req.addr)) else $error("response lost");
	// The pin follows the latched bank one cycle later unless released.
	AST_PIN: assert property (mem_rsp.banked |=>
		port_b_oe_n[8] || port_b_out[8] == $past(bank_lines[0])) else $error("bank pin wrong");
	AST_ERR: assert property (psel && penable && paddr[11] |->
		pslverr) else $error("no error on unmapped access");
	AST_RDY: assert property (psel && penable |-> pready) else $error("no ready");
	cover property (mem_rsp.banked);
	cover property (mem_rsp.onchip);
	cover property (psel && penable && pslverr);
endmodule

bind emb_top emb_top_asserts u_chk (.sys_clk, .resetn, .paddr, .psel, .penable, .pready,
	.pslverr, .mem_req, .mem_rsp, .port_b_out, .port_b_oe_n, .bank_lines);

// >>> tb/emb_ext_mem.sv
`timescale 1ns/1ps
module emb_ext_mem (
	input wire logic                  sys_clk,
	input wire logic                  resetn,
	input wire emb_pkg::emb_mem_rsp_s mem_rsp,
	input wire logic [3:0]            bank_lines,
	output logic [4:0]                ext_page
);
	import emb_pkg::*;
	// Page 16 is the fixed main area, so a bank number can never alias it.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			ext_page <= 5'h00;
		else if (mem_rsp.valid && mem_rsp.ext)
			ext_page <= mem_rsp.banked ? {1'b0, bank_lines} : 5'h10;
	end
endmodule

// >>> tb/emb_top_tb_top.sv
`timescale 1ns/1ps
module emb_top_tb_top;
	import emb_pkg::*;
	logic         sys_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [3:0]   pstrb, bank_lines;
	logic [15:0]  sync_out_data, port_b_in, port_b_out, port_b_oe_n;
	logic [4:0]   ext_page;
	emb_mem_req_s mem_req;
	emb_mem_rsp_s mem_rsp;
	int           n_fail, check_count;

	emb_top uut (.sys_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .mem_req, .mem_rsp, .sync_out_data, .port_b_in,
		.port_b_out, .port_b_oe_n, .bank_lines);
	emb_ext_mem ext (.sys_clk, .resetn, .mem_rsp, .bank_lines, .ext_page);

	// Clock of 100 ns.
	initial begin
		sys_clk = 0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Counts every comparison and reports a mismatch at once.
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask

	// One APB transfer; data and error are taken at the edge where ready is seen.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// A lost ready is a mismatch too; the run ends at once through the one verdict.
		if (pready !== 1'b1) begin
			n_fail++;
			$display("mismatch pready exp 1 got %b", pready);
			test_done();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask

	// A request held for one edge; the response has landed when the task returns.
	task mem_acc(input logic [15:0] a);
		@(posedge sys_clk);
		mem_req <= '{1'b1, a};
		@(posedge sys_clk);
		mem_req.valid <= 1'b0;
		#1;
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence; port_b_in differs from the output latch, so a port read shows the pins.
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata, mem_req} = '0;
		pstrb = 4'hf;
		sync_out_data = 16'h0200;
		port_b_in = 16'h0180;
		n_fail = 0;
		check_count = 0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1;
		apb(0, 12'h3c8, 0);
		chk("dir", 0, rd);
		apb(0, 12'h410, 0);
		chk("ctrl", 32'h0f00, rd);
		// Mode off: line 8 as port output, line 9 as sync output, bank ignored.
		apb(1, 12'h410, 32'h0f50);
		apb(1, 12'h3c8, 32'h0100);
		apb(1, 12'h388, 32'h0100);
		apb(1, 12'h3d0, 32'h0200);
		mem_acc(16'h4000);
		chk("nobank", 0, {mem_rsp.banked, bank_lines});
		@(posedge sys_clk);
		#1;
		chk("gp", 4'hc, {port_b_out[9:8], port_b_oe_n[9:8]});
		// Every bank number reaches the lines and the memory.
		for (int b = 0; b < 16; b++) begin
			apb(1, 12'h410, {20'h0, 4'hf, b[3:0], 4'h1});
			mem_acc(16'h4000);
			chk("bank", {1'b1, b[3:0]}, {mem_rsp.banked, bank_lines});
			@(posedge sys_clk);
			#1;
			chk("pins", b[3:0], {port_b_out[14:13], port_b_out[9:8]});
			chk("page", b[4:0], ext_page);
		end
		chk("oe", 0, {port_b_oe_n[14:13], port_b_oe_n[9:8]});
		mem_acc(16'h01ff);
		chk("onchip", 3'b100, {mem_rsp.onchip, mem_rsp.ext, mem_rsp.banked});
		mem_acc(16'h0200);
		chk("low", 3'b011, {mem_rsp.onchip, mem_rsp.ext, mem_rsp.banked});
		chk("addr", 16'h0200, mem_rsp.addr);
		// A new bank number must not latch on a main access.
		apb(1, 12'h410, 32'h0f31);
		mem_acc(16'h8000);
		chk("main", 7'h2f, {mem_rsp.onchip, mem_rsp.ext, mem_rsp.banked, bank_lines});
		@(posedge sys_clk);
		#1;
		chk("mpage", 5'h10, ext_page);
		// Mask bit clear releases line 8, which still reads as an input.
		apb(1, 12'h410, 32'h0e51);
		mem_acc(16'h1000);
		@(posedge sys_clk);
		#1;
		chk("in", 2'b10, {port_b_oe_n[8], port_b_oe_n[9]});
		apb(0, 12'h388, 0);
		chk("pin", 32'h0180, rd);
		apb(0, 12'h804, 0);
		chk("unmapped", 1, err);
		chk("unmapped_rd", 0, rd);
		apb(1, 12'h414, 1);
		chk("ro", 1, err);
		// Status shows mode on, a banked last access and the latched bank 5.
		apb(0, 12'h414, 0);
		chk("stat", 32'h0057, rd);
		apb(0, 12'h412, 0);
		chk("misal", 1, err);
		chk("misal_rd", 0, rd);
		// Only the low byte lane is written, so the mask in the high byte survives.
		pstrb <= 4'h1;
		apb(1, 12'h410, 32'h0000_0f70);
		pstrb <= 4'hf;
		apb(0, 12'h410, 0);
		chk("lane", 32'h0e70, rd);
		test_done();
	end
endmodule
